// ### logic/ilts_pkg.sv
package ilts_pkg;

    // Sizes of the indicator set and operand bus
    localparam int N_LAMP    = 62;
    localparam int N_PROG    = 48;
    localparam int N_PB      = 12;
    localparam int OPER_W    = 64;
    localparam int SEL_W     = 6;
    localparam int IDX_W     = 6;
    localparam int N_MAJOR   = 8;
    localparam int N_MINOR   = 16;
    localparam int ADDR_W    = 9;
    localparam int TIMER_W   = 30;
    localparam int TRIG_W    = 22;

    // Lamp vector layout, also the scan order
    localparam int LAMP_TRIP  = 0;
    localparam int LAMP_ALARM = 1;
    localparam int LAMP_PROG  = 2;
    localparam int LAMP_PB    = 50;
    localparam logic [IDX_W-1:0] LAST_IDX = 6'h3D;

    // Timing
    localparam int CLK_KHZ   = 10_000;
    localparam int TRIG_MS   = 250;
    localparam int STEP_MS   = 1000;
    localparam int MAX_S     = 60;
    localparam int TRIG_CYC_D = TRIG_MS * CLK_KHZ;
    localparam int STEP_CYC_D = STEP_MS * CLK_KHZ;
    localparam int MAX_CYC_D  = MAX_S * 1000 * CLK_KHZ;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL     = 9'h000;
    localparam logic [ADDR_W-1:0] OFS_TA_SEL   = 9'h004;
    localparam logic [ADDR_W-1:0] OFS_HOLD_LO  = 9'h008;
    localparam logic [ADDR_W-1:0] OFS_HOLD_HI  = 9'h00C;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 9'h010;
    localparam logic [ADDR_W-1:0] OFS_MINOR_EN = 9'h014;
    localparam logic [ADDR_W-1:0] OFS_LAMP_LO  = 9'h018;
    localparam logic [ADDR_W-1:0] OFS_LAMP_HI  = 9'h01C;
    localparam logic [ADDR_W-1:0] OFS_REMOTE   = 9'h020;
    localparam logic [ADDR_W-1:0] OFS_SEL_BASE = 9'h100;

    // Field positions
    localparam int CTRL_EN    = 0;
    localparam int CTRL_TSRC  = 8;
    localparam int CTRL_RSRC  = 16;
    localparam int TA_TRIP    = 0;
    localparam int TA_ALARM   = 8;
    localparam int ST_ACTIVE  = 0;
    localparam int ST_STAGE   = 1;
    localparam int ST_IDX     = 8;

    // Reset values
    localparam logic [SEL_W-1:0]   SEL_RST   = 6'h00;
    localparam logic [N_MINOR-1:0] MINOR_RST = 16'hFFFF;

    typedef enum logic [1:0] {
        ILTS_IDLE     = 2'b00,
        ILTS_ALL_ON   = 2'b01,
        ILTS_WALK_ON  = 2'b11,
        ILTS_WALK_OFF = 2'b10
    } ilts_state_t;

endpackage : ilts_pkg

// ### logic/ilts_top.sv
`timescale 1ns/1ps

// What this block does
// - Lamp test starts only when enabled, trigger from the selected operand.
// - Test drives every lamp, pushbutton lamps included.
// - First stage lights all 62 lamps; held trigger ends test after a minute.
// - Trigger release in first stage moves on to second stage.
// - Second stage: all off, each lamp lit alone for one second.
// - Scan runs top to bottom per column, starting top-left panel.
// - Third stage: all on, each lamp dark alone for one second.
// - Third stage follows the second with no further trigger.
// - New trigger rising edge aborts second or third stage.
// - Trigger pulses shorter than 250 ms are ignored.
// - Functional lamp states keep updating in background, shown after test.
// - Reset key clears no latched targets while test runs.
// - Test active flag is high for the whole test.
// - A start event pulses when the test begins.
// - Trip and alarm lamps follow their selected operands.
// - 48 programmable lamps, each with its own selected operand.
// - Self-reset hold style follows the operand directly.
// - Latched style holds until reset key, remote reset or reset operand.
// - Major self-test alarms always reported.
// - Disabled minor alarms suppressed everywhere, summaries included.
module ilts_top
    import ilts_pkg::*;
#(
    parameter int TRIG_CYC = ilts_pkg::TRIG_CYC_D,
    parameter int STEP_CYC = ilts_pkg::STEP_CYC_D,
    parameter int MAX_CYC  = ilts_pkg::MAX_CYC_D
) (
    input  wire logic                           clk,
    input  wire logic                           reset,
    input  wire logic [ilts_pkg::ADDR_W-1:0]    reg_addr,
    input  wire logic [31:0]                    reg_wdata,
    input  wire logic                           reg_wr,
    input  wire logic                           reg_rd,
    output logic      [31:0]                    reg_rdata,
    input  wire logic [ilts_pkg::OPER_W-1:0]    operand,
    input  wire logic [ilts_pkg::N_PB-1:0]      pb_lamp_state,
    input  wire logic                           reset_key,
    input  wire logic [ilts_pkg::N_MAJOR-1:0]   major_alarm,
    input  wire logic [ilts_pkg::N_MINOR-1:0]   minor_alarm,
    output logic      [ilts_pkg::N_LAMP-1:0]    lamp,
    output logic                                test_active_flag,
    output logic                                test_start_event,
    output logic      [ilts_pkg::N_MAJOR-1:0]   major_oper,
    output logic      [ilts_pkg::N_MINOR-1:0]   minor_oper,
    output logic                                any_minor,
    output logic                                any_self_test,
    output logic                                self_test_event
);

    import ilts_pkg::*;

    // Settings
    logic                 test_feature_switch;
    logic [SEL_W-1:0]     test_trigger_source;
    logic [SEL_W-1:0]     reset_source;
    logic [SEL_W-1:0]     trip_sel;
    logic [SEL_W-1:0]     alarm_sel;
    logic [N_PROG-1:0]    indicator_hold_style;
    logic [N_MINOR-1:0]   minor_en;
    logic [SEL_W-1:0]     prog_sel [N_PROG];
    logic                 remote_reset;

    // Test engine state
    ilts_state_t          state;
    ilts_state_t          next_state;
    logic [TIMER_W-1:0]   timer;
    logic [TIMER_W-1:0]   next_timer;
    logic [IDX_W-1:0]     idx;
    logic [IDX_W-1:0]     next_idx;
    logic [TRIG_W-1:0]    trig_cnt;
    logic                 trig_q;
    logic                 trig_q_d;
    logic [N_PROG-1:0]    prog_state;
    logic [N_LAMP-1:0]    func_lamp;
    logic [N_LAMP-1:0]    next_lamp;
    logic [N_MAJOR+N_MINOR-1:0] alarm_prev;

    // Operand slot zero is the "off" choice
    wire [OPER_W-1:0] oper_eff = {operand[OPER_W-1:1], 1'b0};

    wire trig_raw   = oper_eff[test_trigger_source];
    wire trig_rise  = trig_q & ~trig_q_d;
    wire trig_full  = (trig_cnt == TRIG_W'(TRIG_CYC - 1));
    wire step_done  = (timer == TIMER_W'(STEP_CYC - 1));
    wire max_done   = (timer == TIMER_W'(MAX_CYC - 1));
    wire last_lamp  = (idx == LAST_IDX);
    wire testing    = (state != ILTS_IDLE);
    wire start_test = (state == ILTS_IDLE) & test_feature_switch & trig_rise;

    // State, not the registered flag, so the block starts with the test
    // reset key blocked during test
    wire key_clr    = reset_key & ~testing;
    wire latch_clr  = key_clr | remote_reset | oper_eff[reset_source];

    // Register decode
    wire wr_ctrl   = reg_wr & (reg_addr == OFS_CTRL);
    wire wr_ta     = reg_wr & (reg_addr == OFS_TA_SEL);
    wire wr_hlo    = reg_wr & (reg_addr == OFS_HOLD_LO);
    wire wr_hhi    = reg_wr & (reg_addr == OFS_HOLD_HI);
    wire wr_minor  = reg_wr & (reg_addr == OFS_MINOR_EN);
    wire wr_remote = reg_wr & (reg_addr == OFS_REMOTE);
    wire [IDX_W-1:0] sel_idx = reg_addr[IDX_W+1:2];
    wire in_sel    = (reg_addr[ADDR_W-1:IDX_W+2] == OFS_SEL_BASE[ADDR_W-1:IDX_W+2])
                     & (sel_idx < IDX_W'(N_PROG)) & (reg_addr[1:0] == 2'h0);
    wire wr_sel    = reg_wr & in_sel;

    always_ff @(posedge clk) begin
        if (reset) begin
            test_feature_switch <= 1'b0;
            test_trigger_source <= SEL_RST;
            reset_source        <= SEL_RST;
        end else if (wr_ctrl) begin
            test_feature_switch <= reg_wdata[CTRL_EN];
            test_trigger_source <= reg_wdata[CTRL_TSRC +: SEL_W];
            reset_source        <= reg_wdata[CTRL_RSRC +: SEL_W];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            trip_sel  <= SEL_RST;
            alarm_sel <= SEL_RST;
        end else if (wr_ta) begin
            trip_sel  <= reg_wdata[TA_TRIP +: SEL_W];
            alarm_sel <= reg_wdata[TA_ALARM +: SEL_W];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            indicator_hold_style <= '0;
        end else if (wr_hlo) begin
            indicator_hold_style[31:0] <= reg_wdata;
        end else if (wr_hhi) begin
            indicator_hold_style[N_PROG-1:32] <= reg_wdata[N_PROG-33:0];
        end
    end

    // minor enables; remote reset lasts one cycle only
    always_ff @(posedge clk) begin
        if (reset) begin
            minor_en     <= MINOR_RST;
            remote_reset <= 1'b0;
        end else begin
            remote_reset <= wr_remote & reg_wdata[0];
            if (wr_minor) begin
                minor_en <= reg_wdata[N_MINOR-1:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < N_PROG; i++) begin
                prog_sel[i] <= SEL_RST;
            end
        end else if (wr_sel) begin
            prog_sel[sel_idx] <= reg_wdata[SEL_W-1:0];
        end
    end

    // Read mux; an out-of-range index would read past the select array
    wire [IDX_W-1:0] sel_rd_idx = in_sel ? sel_idx : '0;
    wire [31:0] status_word = {16'h0000, 2'b00, idx, 5'h00, state, testing};
    wire [31:0] sel_word    = {26'h0, prog_sel[sel_rd_idx]};
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (reg_addr)
            OFS_CTRL: begin
                rd_mux[CTRL_EN]             = test_feature_switch;
                rd_mux[CTRL_TSRC +: SEL_W]  = test_trigger_source;
                rd_mux[CTRL_RSRC +: SEL_W]  = reset_source;
            end
            OFS_TA_SEL: begin
                rd_mux[TA_TRIP +: SEL_W]  = trip_sel;
                rd_mux[TA_ALARM +: SEL_W] = alarm_sel;
            end
            OFS_HOLD_LO:  rd_mux = indicator_hold_style[31:0];
            OFS_HOLD_HI:  rd_mux = {16'h0000, indicator_hold_style[N_PROG-1:32]};
            OFS_STATUS:   rd_mux = status_word;
            OFS_MINOR_EN: rd_mux = {16'h0000, minor_en};
            OFS_LAMP_LO:  rd_mux = func_lamp[31:0];
            OFS_LAMP_HI:  rd_mux = {2'b00, func_lamp[N_LAMP-1:32]};
            default: begin
                if (in_sel) begin
                    rd_mux = sel_word;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 32'h0000_0000;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            trig_cnt <= '0;
            trig_q   <= 1'b0;
            trig_q_d <= 1'b0;
        end else begin
            trig_q_d <= trig_q;
            // Count stops at the limit, so a long hold never wraps
            if (!trig_raw) begin
                trig_cnt <= '0;
                trig_q   <= 1'b0;
            end else if (trig_full) begin
                trig_q <= 1'b1;
            end else begin
                trig_cnt <= trig_cnt + TRIG_W'(1);
            end
        end
    end

    // Functional lamp states, always updated
    generate
        for (genvar g = 0; g < N_PROG; g++) begin : g_prog
            wire op = oper_eff[prog_sel[g]];
            always_ff @(posedge clk) begin
                if (reset) begin
                    prog_state[g] <= 1'b0;
                end else if (indicator_hold_style[g]) begin
                    prog_state[g] <= op | (prog_state[g] & ~latch_clr);
                end else begin
                    prog_state[g] <= op;
                end
            end
        end
    endgenerate

    // Pushbutton lamps arrive finished; only the test overrides them
    // stored states kept during test
    assign func_lamp = {pb_lamp_state, prog_state,
                        oper_eff[alarm_sel], oper_eff[trip_sel]};

    // Test sequencer
    always_comb begin
        next_state = state;
        next_timer = timer + TIMER_W'(1);
        next_idx   = idx;
        case (state)
            ILTS_IDLE: begin
                next_timer = '0;
                next_idx   = '0;
                if (start_test) begin
                    next_state = ILTS_ALL_ON;
                end
            end
            // Edges here are ignored; only release, timeout or dropping the feature leave
            ILTS_ALL_ON: begin
                if (!trig_q) begin
                    next_state = ILTS_WALK_ON;
                    next_timer = '0;
                    next_idx   = '0;
                end else if (max_done) begin
                    next_state = ILTS_IDLE;
                end
            end
            ILTS_WALK_ON, ILTS_WALK_OFF: begin
                if (trig_rise) begin
                    next_state = ILTS_IDLE;
                end else if (step_done) begin
                    next_timer = '0;
                    next_idx   = idx + IDX_W'(1);
                    if (last_lamp) begin
                        next_idx = '0;
                        next_state = (state == ILTS_WALK_ON) ? ILTS_WALK_OFF : ILTS_IDLE;
                    end
                end
            end
            default: begin
                next_state = ILTS_IDLE;
            end
        endcase
        // Dropping the feature mid-test abandons the test
        if (!test_feature_switch) begin
            next_state = ILTS_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state <= ILTS_IDLE;
            timer <= '0;
            idx   <= '0;
        end else begin
            state <= next_state;
            timer <= next_timer;
            idx   <= next_idx;
        end
    end

    // Lamp drive from next_state, so lamps switch in step with the flag
    // Scan index equals lamp bit, so vector order is the scan order
    wire [N_LAMP-1:0] one_hot = N_LAMP'(1) << next_idx;
    always_comb begin
        case (next_state)
            ILTS_ALL_ON:   next_lamp = '1;
            ILTS_WALK_ON:  next_lamp = one_hot;
            ILTS_WALK_OFF: next_lamp = ~one_hot;
            default:       next_lamp = func_lamp;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            lamp             <= '0;
            test_active_flag <= 1'b0;
            test_start_event <= 1'b0;
        end else begin
            lamp             <= next_lamp;
            test_active_flag <= (next_state != ILTS_IDLE);
            test_start_event <= start_test & test_feature_switch;
        end
    end

    // Self-test alarm gating
    // mask disabled minors
    wire [N_MINOR-1:0] minor_g = minor_alarm & minor_en;
    wire [N_MAJOR+N_MINOR-1:0] alarm_all = {minor_g, major_alarm};

    always_ff @(posedge clk) begin
        if (reset) begin
            major_oper      <= '0;
            minor_oper      <= '0;
            any_minor       <= 1'b0;
            any_self_test   <= 1'b0;
            self_test_event <= 1'b0;
            alarm_prev      <= '0;
        end else begin
            major_oper      <= major_alarm;
            minor_oper      <= minor_g;
            any_minor       <= |minor_g;
            any_self_test   <= |alarm_all;
            alarm_prev      <= alarm_all;
            // New alarm only; repeats of a held alarm stay silent
            self_test_event <= |(alarm_all & ~alarm_prev);
        end
    end

endmodule : ilts_top

// ### verif/ilts_trig_src.sv
`timescale 1ns/1ps
module ilts_trig_src (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [7:0] len,
    output logic            trig
);
    logic [7:0] left = 8'h00;
    always_ff @(posedge clk) begin
        if (go) begin
            left <= len;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end
    // Operand source drives low between pulses
    assign trig = (left != 8'h00);
endmodule : ilts_trig_src

// ### verif/ilts_top_props.sv
`timescale 1ns/1ps
module ilts_top_chk
    import ilts_pkg::*;
#(
    parameter int TRIG_CYC = 4,
    parameter int STEP_CYC = 8,
    parameter int MAX_CYC  = 50
) (
    input wire logic                        clk,
    input wire logic                        reset,
    input wire logic [ilts_pkg::N_LAMP-1:0] lamp,
    input wire logic                        test_active_flag,
    input wire logic                        test_start_event,
    input wire logic [ilts_pkg::N_MAJOR-1:0] major_alarm,
    input wire logic [ilts_pkg::N_MAJOR-1:0] major_oper,
    input wire logic [ilts_pkg::N_MINOR-1:0] minor_alarm,
    input wire logic [ilts_pkg::N_MINOR-1:0] minor_oper,
    input wire logic                        any_minor,
    input wire logic                        any_self_test
);
    import ilts_pkg::*;
    localparam logic [N_LAMP-1:0] ALL = '1;
    int on_cnt;
    // Counts cycles spent in the all-on stage
    always_ff @(posedge clk) begin
        if (reset || !(test_active_flag && lamp == ALL)) begin
            on_cnt <= 0;
        end else begin
            on_cnt <= on_cnt + 1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_start_with_flag: assert property ($rose(test_active_flag) |-> test_start_event)
        else $error("start pulse missing at flag rise");
    a_start_single: assert property (test_start_event |=> !test_start_event)
        else $error("start pulse longer than one cycle");
    a_all_lamps_on: assert property (test_start_event |-> lamp == ALL)
        else $error("lamps not all on at test start");
    a_walk_first: assert property (test_active_flag && $past(lamp) == ALL &&
        $countones(lamp) == 1 |-> lamp[0])
        else $error("walk does not start at first lamp");
    // Lower bound only: 7 fits the short step used in simulation
    a_step_hold: assert property (test_active_flag && $countones(lamp) == 1 &&
        lamp != $past(lamp) |=> (!test_active_flag || $stable(lamp))[*7])
        else $error("walk step shorter than expected");
    a_stage_limit: assert property (on_cnt <= MAX_CYC + 1)
        else $error("all-on stage exceeded its limit");
    a_major_copy: assert property (!$past(reset) |-> major_oper == $past(major_alarm))
        else $error("major alarm not passed on");
    a_minor_gate: assert property ((minor_oper & ~$past(minor_alarm)) == '0)
        else $error("minor operand without raw alarm");
    a_summary_or: assert property (any_minor == (|minor_oper) &&
        any_self_test == ((|major_oper) || (|minor_oper)))
        else $error("summary flags disagree with operands");
    c_start: cover property (test_start_event);
    c_walk: cover property (test_active_flag && lamp == 62'h1);
    c_end: cover property ($fell(test_active_flag));
endmodule : ilts_top_chk

bind ilts_top ilts_top_chk #(.TRIG_CYC(TRIG_CYC), .STEP_CYC(STEP_CYC), .MAX_CYC(MAX_CYC)) u_chk (
    .clk(clk), .reset(reset), .lamp(lamp), .test_active_flag(test_active_flag),
    .test_start_event(test_start_event), .major_alarm(major_alarm), .major_oper(major_oper),
    .minor_alarm(minor_alarm), .minor_oper(minor_oper), .any_minor(any_minor),
    .any_self_test(any_self_test));

// ### verif/tb.sv
`timescale 1ns/1ps
module tb;
    import ilts_pkg::*;
    typedef struct packed {
        logic [63:0] op;
        logic [11:0] pb;
        logic [7:0]  maj;
        logic [15:0] mnr;
        logic        ev;
    } ilts_row_t;
    localparam logic [N_LAMP-1:0] ALL_ON = '1;
    localparam logic [62:0] FLAG = {1'b1, 62'h0};
    logic clk, reset, reg_wr, reg_rd, reset_key, go, trig, any_minor, any_self_test;
    logic test_active_flag, test_start_event, self_test_event;
    logic [8:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [63:0] op_base, operand;
    logic [7:0] len, maj, major_oper;
    logic [11:0] pb;
    logic [15:0] mnr, minor_oper;
    logic [61:0] lamp;
    int err_total, check_count;
    ilts_row_t rows [4] = '{
        '{64'h0, 12'h000, 8'h00, 16'h0000, 1'b0},
        '{64'h5555_5555_5555_5514, 12'hA5A, 8'h81, 16'hF00F, 1'b1},
        '{64'hCCCC_CCCC_CCCC_CC88, 12'h3C3, 8'h00, 16'h0F00, 1'b0},
        '{64'hFFFF_FFFF_FFFF_FF9F, 12'hFFF, 8'hFF, 16'hFFFF, 1'b1}};
    assign operand = {op_base[63:6], trig, op_base[4:0]};
    ilts_top #(.TRIG_CYC(4), .STEP_CYC(8), .MAX_CYC(50)) dut (
        .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .operand(operand),
        .pb_lamp_state(pb), .reset_key(reset_key), .major_alarm(maj), .minor_alarm(mnr),
        .lamp(lamp), .test_active_flag(test_active_flag), .test_start_event(test_start_event),
        .major_oper(major_oper), .minor_oper(minor_oper), .any_minor(any_minor),
        .any_self_test(any_self_test), .self_test_event(self_test_event));
    ilts_trig_src src (.clk(clk), .go(go), .len(len), .trig(trig));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    function automatic logic [61:0] exp_lamp(input logic [63:0] op, input logic [11:0] p);
        logic [61:0] l;
        l = {p, 50'h0};
        l[0] = op[1];
        l[1] = op[2];
        for (int k = 0; k < 48; k++) l[2+k] = op[7+k];
        return l;
    endfunction : exp_lamp
    task automatic results;
        if (err_total == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wr(input logic [8:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [8:0] a, output logic [31:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    task automatic pulse(input logic [7:0] n);
        @(posedge clk);
        len <= n;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask : pulse
    // Bounded wait on flag and lamps under a mask
    task automatic wait_on(input logic [62:0] m, input logic [62:0] v, input int n);
        repeat (n) begin
            cyc(1);
            if (({test_active_flag, lamp} & m) === v) return;
        end
        err_total++;
        $display("[FAIL] %0t wait ran out", $time);
        results();
    endtask : wait_on
    initial begin
        {reset, reg_wr, reg_rd, reset_key, go} = 5'h10;
        {reg_addr, reg_wdata, op_base, len, pb, maj, mnr} = '0;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        rd(OFS_MINOR_EN, d);
        chk(64'(d), 64'hFFFF);
        wr(OFS_CTRL, 32'h0006_0501);
        wr(OFS_TA_SEL, 32'h0000_0201);
        wr(OFS_MINOR_EN, 32'h0000_00FF);
        for (int i = 0; i < 48; i++) wr(OFS_SEL_BASE + 9'(4 * i), 32'(7 + i));
        foreach (rows[r]) begin
            @(posedge clk);
            {op_base, pb, maj, mnr} <= {rows[r].op, rows[r].pb, rows[r].maj, rows[r].mnr};
            cyc(1);
            chk(64'(self_test_event), 64'(rows[r].ev));
            cyc(2);
            chk(64'(lamp), 64'(exp_lamp(rows[r].op, rows[r].pb)));
            chk(64'({major_oper, minor_oper, any_minor, any_self_test}), 64'({rows[r].maj,
                rows[r].mnr & 16'h00FF, |(rows[r].mnr & 16'h00FF),
                (|rows[r].maj) || (|(rows[r].mnr & 16'h00FF))}));
        end
        @(posedge clk);
        {op_base, pb, maj, mnr} <= '0;
        wr(OFS_HOLD_LO, 32'h0000_0001);
        @(posedge clk);
        op_base <= 64'h80;
        repeat (2) @(posedge clk);
        op_base <= 64'h0;
        cyc(3);
        chk(64'(lamp), 64'h4);
        pulse(8'h0A);
        wait_on(FLAG, FLAG, 20);
        chk(64'(lamp), 64'(ALL_ON));
        // Key press and trip change while test drives the lamps
        @(posedge clk);
        reset_key <= 1'b1;
        op_base <= 64'h2;
        @(posedge clk);
        reset_key <= 1'b0;
        wait_on('1, {1'b1, 62'h1}, 30);
        wait_on('1, {1'b1, 62'h2}, 12);
        wait_on(FLAG, 63'h0, 1100);
        chk(64'(lamp), 64'h5);
        @(posedge clk);
        reset_key <= 1'b1;
        @(posedge clk);
        reset_key <= 1'b0;
        cyc(2);
        chk(64'(lamp), 64'h1);
        rd(OFS_CTRL, d);
        chk(64'(d), 64'h0006_0501);
        rd(9'h040, d);
        chk(64'(d), 64'h0);
        pulse(8'h0A);
        wait_on('1, {1'b1, 62'h1}, 30);
        cyc(3);
        pulse(8'h06);
        wait_on(FLAG, 63'h0, 15);
        cyc(10);
        pulse(8'h03);
        cyc(10);
        chk(64'(test_active_flag), 64'h0);
        pulse(8'h50);
        wait_on(FLAG, FLAG, 20);
        wait_on(FLAG, 63'h0, 60);
        chk(64'(trig), 64'h1);
        cyc(40);
        chk(64'(test_active_flag), 64'h0);
        wr(OFS_CTRL, 32'h0006_0500);
        pulse(8'h0A);
        cyc(15);
        chk(64'(test_active_flag), 64'h0);
        results();
    end
endmodule : tb
